// file: hw/cilt_pkg.sv
/*
  Constants and types for the CAN internal loop-back test-mode block.
  Assumes an APB master with 32-bit data and a CAN engine next to it.
*/
package cilt_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STAT     = 12'h004;
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_TST_LSB  = 8;
  localparam int          STAT_RST_BIT  = 0;
  localparam int          STAT_HALT_BIT = 1;
  localparam int          STAT_BUSY_BIT = 2;

  // --------------------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------------------
  localparam logic [1:0] OPM_OPER   = 2'h0;
  localparam logic [1:0] OPM_RESET  = 2'h1;
  localparam logic [1:0] OPM_HALT   = 2'h2;
  localparam logic [1:0] TST_NONE   = 2'h0;
  localparam logic [1:0] TST_LISTEN = 2'h1;
  localparam logic [1:0] TST_EXTLB  = 2'h2;
  localparam logic [1:0] TST_INTLB  = 2'h3;
  localparam logic       RECESSIVE  = 1'h1;

  // Longest frame the host should wait out: extended data frame plus stuffing.
  localparam int FRAME_BITS = 130;
  localparam int STUFF_BITS = 30;
  localparam int MAX_FRAME_BITS = FRAME_BITS + STUFF_BITS;

  typedef enum logic [1:0] {M_OPER, M_RESET, M_HALT} cilt_mode_t;

endpackage

// file: hw/cilt_core.sv
/*
  Test-mode routing and operating-mode control of one CAN channel.
  Assumes a CAN engine that serialises frames on eng_tx_i, samples eng_rx_o,
  and reports a frame in progress on eng_busy_i; all inputs are synchronous.
*/
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module cilt_core
  import cilt_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              eng_tx_i,
  input  wire logic              eng_busy_i,
  output logic                   eng_rx_o,
  output logic                   eng_self_ack_o,
  output logic                   eng_store_own_o,
  output logic                   eng_listen_only_o,
  output logic                   eng_enable_o,
  input  wire logic              bus_receive_pin_i,
  output logic                   bus_transmit_pin_o
);

  typedef struct packed {
    cilt_mode_t  mode;
    logic [1:0]  req;
    logic [1:0]  tst;
    logic        rx;
    logic        txp;
    logic        ack;
    logic        own;
    logic        lsn;
    logic        en;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
  } cilt_state_t;

  cilt_state_t q;
  cilt_state_t d;
  logic        setup;
  logic        take;
  logic        hit_ctrl;
  logic        hit_stat;
  logic [1:0]  tst_act;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  // The test routing is frozen out in reset mode so a stale select cannot
  // disturb the pins while software is reconfiguring.
  assign tst_act  = (q.mode == M_RESET) ? TST_NONE : q.tst;
  assign setup    = psel_i & ~penable_i;
  assign take     = psel_i & penable_i & q.rdy;
  assign hit_ctrl = (paddr_i == ADDR_CTRL);
  assign hit_stat = (paddr_i == ADDR_STAT);

  always_comb begin
    d     = q;
    d.rdy = setup;
    if (setup) begin
      d.rdata = '0;
      d.err   = 1'b0;
      if (hit_ctrl) begin
        d.rdata[CTRL_MODE_LSB +: 2] = q.req;
        d.rdata[CTRL_TST_LSB +: 2]  = q.tst;
      end else if (hit_stat) begin
        d.rdata[STAT_RST_BIT]  = (q.mode == M_RESET);
        d.rdata[STAT_HALT_BIT] = (q.mode == M_HALT);
        d.rdata[STAT_BUSY_BIT] = eng_busy_i;
      end else begin
        d.err = 1'b1;
      end
    end
    if (take && pwrite_i && hit_ctrl) begin
      d.req = pwdata_i[CTRL_MODE_LSB +: 2];
      // The select only moves in halt mode, so routing never flips mid-frame.
      if (q.mode == M_HALT) begin
        d.tst = pwdata_i[CTRL_TST_LSB +: 2];
      end
    end

    case (q.mode)
      M_OPER: begin
        if (q.req == OPM_RESET && !eng_busy_i) begin
          d.mode = M_RESET;
        end else if (q.req == OPM_HALT && !eng_busy_i) begin
          d.mode = M_HALT;
        end
      end
      M_HALT: begin
        if (q.req == OPM_RESET) begin
          d.mode = M_RESET;
        end else if (q.req == OPM_OPER) begin
          d.mode = M_OPER;
        end
      end
      default: begin
        if (q.req == OPM_HALT) begin
          d.mode = M_HALT;
        end else if (q.req == OPM_OPER) begin
          d.mode = M_OPER;
        end
      end
    endcase
    d.en = (d.mode == M_OPER);

    case (tst_act)
      TST_INTLB: begin
        d.rx  = eng_tx_i;
        d.txp = RECESSIVE;
        d.ack = 1'b1;
        d.own = 1'b1;
        d.lsn = 1'b0;
      end
      TST_EXTLB: begin
        d.rx  = bus_receive_pin_i;
        d.txp = eng_tx_i;
        d.ack = 1'b1;
        d.own = 1'b1;
        d.lsn = 1'b0;
      end
      TST_LISTEN: begin
        // Dominant bits the engine asks for are seen internally only.
        d.rx  = bus_receive_pin_i & eng_tx_i;
        d.txp = RECESSIVE;
        d.ack = 1'b0;
        d.own = 1'b0;
        d.lsn = 1'b1;
      end
      default: begin
        d.rx  = bus_receive_pin_i;
        d.txp = eng_tx_i;
        d.ack = 1'b0;
        d.own = 1'b0;
        d.lsn = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q       <= '0;
      q.mode  <= M_RESET;
      q.req   <= OPM_RESET;
      q.tst   <= TST_NONE;
      q.rx    <= RECESSIVE;
      q.txp   <= RECESSIVE;
    end else begin
      q <= d;
    end
  end

  assign prdata_o           = q.rdata;
  assign pready_o           = q.rdy;
  assign pslverr_o          = q.err;
  assign eng_rx_o           = q.rx;
  assign eng_self_ack_o     = q.ack;
  assign eng_store_own_o    = q.own;
  assign eng_listen_only_o  = q.lsn;
  assign eng_enable_o       = q.en;
  assign bus_transmit_pin_o = q.txp;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_intlb_store_own: assert property (
    tst_act == TST_INTLB |=> eng_store_own_o)
    else $error("own frames not stored in internal loop-back");
  a_intlb_self_ack: assert property (
    tst_act == TST_INTLB |=> eng_self_ack_o)
    else $error("no self acknowledge in internal loop-back");
  a_intlb_rx_loop: assert property (
    tst_act == TST_INTLB |=> eng_rx_o == $past(eng_tx_i))
    else $error("receive input not fed from transmit bit");
  a_intlb_pin_ignored: assert property (
    tst_act == TST_INTLB && bus_receive_pin_i != eng_tx_i
    |=> eng_rx_o != $past(bus_receive_pin_i))
    else $error("receive pin leaked in internal loop-back");
  a_intlb_tx_recessive: assert property (
    tst_act == TST_INTLB [*2] |=> bus_transmit_pin_o == RECESSIVE)
    else $error("transmit pin not recessive in internal loop-back");
  a_select_intlb: assert property (
    take && pwrite_i && hit_ctrl && q.mode == M_HALT
    && pwdata_i[CTRL_TST_LSB +: 2] == TST_INTLB
    |=> q.tst == TST_INTLB ##1 eng_store_own_o)
    else $error("select 11 did not enter internal loop-back");
  a_listen_mode: assert property (
    tst_act == TST_LISTEN |=> eng_listen_only_o
    && bus_transmit_pin_o == RECESSIVE && !eng_self_ack_o)
    else $error("listen-only routing wrong");
  a_extlb_mode: assert property (
    tst_act == TST_EXTLB |=> bus_transmit_pin_o == $past(eng_tx_i)
    && eng_self_ack_o)
    else $error("external loop-back routing wrong");
  a_halt_waits: assert property (
    q.mode == M_OPER && q.req == OPM_HALT && eng_busy_i
    |=> q.mode == M_OPER)
    else $error("halt entered during a frame");
  a_halt_flag: assert property (
    q.mode == M_OPER && q.req == OPM_HALT && !eng_busy_i
    |=> q.mode == M_HALT ##1 !eng_enable_o)
    else $error("halt not entered when idle");
  a_normal_route: assert property (
    tst_act == TST_NONE |=> eng_rx_o == $past(bus_receive_pin_i)
    && bus_transmit_pin_o == $past(eng_tx_i))
    else $error("normal routing wrong");

  c_intlb_run: cover property (
    tst_act == TST_INTLB && q.mode == M_OPER && eng_busy_i);
  c_halt_delayed: cover property (
    q.req == OPM_HALT && eng_busy_i ##1 !eng_busy_i ##1 q.mode == M_HALT);
  c_bad_addr: cover property (setup && !hit_ctrl && !hit_stat);

endmodule // cilt_core

`default_nettype wire

// file: sim/cilt_xcvr.sv
/*
  Behavioural bus transceiver for the loop-back block.
  Assumes one other node whose bit wire-ANDs with ours.
*/
`timescale 1ns/1ps
`default_nettype none

module cilt_xcvr (
  input  wire logic tx_pin_i,
  input  wire logic other_bit_i,
  output logic      rx_pin_o
);
  // Dominant wins on the bus, so the pin shows the AND of both drivers.
  assign rx_pin_o = tx_pin_i & other_bit_i;
endmodule // cilt_xcvr

`default_nettype wire

// file: sim/tb_top.sv
/*
  Self-checking bench for cilt_core over APB.
  Assumes the transceiver model closes the external pin loop.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import cilt_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic etx, ebusy, erx, eack, eown, elis, een, rxp, txp, oth;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        e;
  int n_errors, samples_checked;

  cilt_core dut (.core_clk_i(clk), .rst_i(rst), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .eng_tx_i(etx), .eng_busy_i(ebusy),
    .eng_rx_o(erx), .eng_self_ack_o(eack), .eng_store_own_o(eown),
    .eng_listen_only_o(elis), .eng_enable_o(een),
    .bus_receive_pin_i(rxp), .bus_transmit_pin_o(txp));
  cilt_xcvr xcvr (.tx_pin_i(txp), .other_bit_i(oth), .rx_pin_o(rxp));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict;
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic ck(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Host waits are bounded by one maximum frame of polls.
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int i;
    for (i = 0; i < MAX_FRAME_BITS; i++) begin
      apb(1'b0, ADDR_STAT, 32'h0);
      if ((r & m) === v) return;
    end
    n_errors++;
    give_verdict();
  endtask

  task automatic drv(input logic t, input logic o);
    @(posedge clk);
    etx <= t; oth <= o;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; etx = 1'b1; ebusy = 1'b0;
    oth = 1'b1; n_errors = 0; samples_checked = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_STAT, 32'h0);
    ck(r, 32'h1);
    for (int b = 0; b < 2; b++) begin
      drv(b[0], 1'b1);
      ck(32'({erx, txp}), 32'({b[0], b[0]}));
    end
    apb(1'b1, ADDR_CTRL, 32'h0);
    poll(32'h3, 32'h0);
    ck(32'(een), 32'h1);
    // Halt is requested from operation with a frame running, so it must wait.
    @(posedge clk);
    ebusy <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h2);
    repeat (5) @(posedge clk);
    apb(1'b0, ADDR_STAT, 32'h0);
    ck(r, 32'h4);
    ebusy <= 1'b0;
    poll(32'h3, 32'h2);
    ck(r, 32'h2);
    for (int t = 1; t < 4; t++) begin
      apb(1'b1, ADDR_CTRL, 32'h2 | (t << 8));
      drv(1'b0, 1'b1);
      ck(32'({erx, txp, eack, eown, elis, een}),
         t == 1 ? 32'h12 : t == 2 ? 32'h0C : 32'h1C);
    end
    apb(1'b1, ADDR_CTRL, 32'h300);
    ebusy <= 1'b1;
    drv(1'b1, 1'b0);
    ck(32'({erx, txp, eack, eown, een}), 32'h1F);
    ebusy <= 1'b0;
    drv(1'b0, 1'b1);
    ck(32'({erx, txp}), 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    ck(r, 32'h0);
    // In reset mode the stored loop-back select must not steer the pins.
    apb(1'b1, ADDR_CTRL, 32'h301);
    poll(32'h3, 32'h1);
    drv(1'b0, 1'b1);
    ck(32'({erx, txp, eack, eown}), 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h300);
    poll(32'h3, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    ck(32'(e), 32'h1);
    ck(r, 32'h0);
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
